/* rtl/adcsq_pkg.sv */
`default_nettype none
package adcsq_pkg;
  // clock and timing
  localparam int CLK_NS = 10;            // pclk period, 100 MHz
  localparam int RC_TAD_NS = 4000;       // typical internal rc bit period
  localparam int RC_HALF_CYC = (RC_TAD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_DIV2 = 8'h01;   // half bit period, osc/2
  localparam logic [7:0] HALF_DIV8 = 8'h04;   // osc/8
  localparam logic [7:0] HALF_DIV32 = 8'h10;  // osc/32
  localparam logic [7:0] HALF_RC = 8'(RC_HALF_CYC);
  localparam int HALF_TICKS = 19;         // 9.5 bit periods in halves
  localparam logic [4:0] STEP_HOLD = 5'h02;   // last acquisition half tick
  localparam logic [4:0] STEP_LAST = 5'h12;   // final decision half tick
  localparam logic [7:0] DAC_FIRST = 8'h80;   // first trial code
  // apb map: register indices, byte address is four times the index
  localparam int APB_AW = 12;
  localparam logic [9:0] IDX_STATUS = 10'h00c;
  localparam logic [9:0] IDX_RESULT = 10'h01e;
  localparam logic [9:0] IDX_CTRL_A = 10'h01f;
  localparam logic [9:0] IDX_PINCFG = 10'h09f;
  // converter_control_a fields
  localparam int CS_MSB = 7;
  localparam int CS_LSB = 6;
  localparam int CH_MSB = 5;
  localparam int CH_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ON_BIT = 0;
  localparam int PC_MSB = 2;       // pin_config_field top bit
  localparam int DONE_BIT = 0;     // status: conversion_done_flag
  // reset values
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] PINCFG_RST = 3'h0;
  localparam logic [2:0] CHSEL_RST = 3'h0;
  // compare unit special event trigger mode
  localparam logic [3:0] TRIG_MODE = 4'hb;
  // conversion clock choices
  typedef enum logic [1:0] {
    CS_OSC2 = 2'b00,
    CS_OSC8 = 2'b01,
    CS_OSC32 = 2'b10,
    CS_RC = 2'b11
  } adcsq_clksel_type;
  // converter sequencer states, one-hot
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b01,
    SAR_RUN = 2'b10
  } adcsq_sar_state_type;
  // half bit period in pclk cycles for a clock choice
  function automatic logic [7:0] half_div(input adcsq_clksel_type sel);
    case (sel)
      CS_OSC2: half_div = HALF_DIV2;
      CS_OSC8: half_div = HALF_DIV8;
      CS_OSC32: half_div = HALF_DIV32;
      default: half_div = HALF_RC;
    endcase
  endfunction
endpackage
`default_nettype wire

/* rtl/adcsq_conv_if.sv */
`default_nettype none
interface adcsq_conv_if;
  import adcsq_pkg::*;
  logic start;                    // begin a conversion, one cycle
  logic abort;                    // drop conversion, one cycle
  adcsq_clksel_type clk_sel;      // chosen conversion clock
  logic sleep;                    // device asleep
  logic comp;                     // latched comparator, 1 = input at or above trial
  logic busy;                     // conversion running
  logic done;                     // conversion finished, one cycle
  logic [7:0] result;             // final code, valid with done
  logic [7:0] dac;                // trial code to the analog side
  logic hold;                     // sample-and-hold in hold
  modport ctl (output start, abort, clk_sel, sleep, comp,
               input busy, done, result, dac, hold);
  modport sar (input start, abort, clk_sel, sleep, comp,
               output busy, done, result, dac, hold);
endinterface
`default_nettype wire

/* rtl/adcsq_sar.sv */
`default_nettype none
module adcsq_sar (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  adcsq_conv_if.sar cif
);
  import adcsq_pkg::*;

  adcsq_sar_state_type state_r;    // sequencer state
  adcsq_clksel_type sel_r;         // clock choice latched at start
  logic [7:0] half_cnt_r;          // pclk count inside a half period
  logic [4:0] step_r;              // half period index
  logic [7:0] dac_r;               // trial code
  logic [7:0] dac_nxt;
  logic hold_r;
  logic done_r;
  logic [7:0] result_r;
  logic clk_live;                  // conversion clock running
  logic tick;                      // end of one half period
  logic [2:0] bit_idx;             // bit decided at this step

  // osc clocks stop in sleep; only the rc clock keeps running
  assign clk_live = !cif.sleep || (sel_r == CS_RC);
  assign tick = (state_r == SAR_RUN) && clk_live && (half_cnt_r == half_div(sel_r) - 8'h01);
  assign bit_idx = 3'(5'h09 - (step_r >> 1));

  // one bit decision per bit period, msb first
  always_comb begin
    dac_nxt = dac_r;
    if (step_r == STEP_HOLD) begin
      dac_nxt = DAC_FIRST;
    end else if (step_r > STEP_HOLD + 5'h01 && !step_r[0]) begin
      if (!cif.comp) begin
        dac_nxt[bit_idx] = 1'b0;     // input below trial, drop the bit
      end
      if (bit_idx != 3'h0) begin
        dac_nxt[bit_idx - 3'h1] = 1'b1;
      end
    end
  end

  // state and timing; reset or abort drops any conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SAR_IDLE;
      sel_r <= CS_OSC2;
      half_cnt_r <= 8'h00;
      step_r <= 5'h00;
      dac_r <= 8'h00;
      hold_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        SAR_IDLE: begin
          if (cif.start) begin
            // clock choice frozen so a mid-run write cannot skew timing
            sel_r <= cif.clk_sel;
            half_cnt_r <= 8'h00;
            step_r <= 5'h00;
            dac_r <= 8'h00;
            hold_r <= 1'b1;
            state_r <= SAR_RUN;
          end
        end
        SAR_RUN: begin
          if (cif.abort) begin
            hold_r <= 1'b0;
            state_r <= SAR_IDLE;
          end else if (clk_live) begin
            half_cnt_r <= tick ? 8'h00 : half_cnt_r + 8'h01;
            if (tick) begin
              dac_r <= dac_nxt;
              step_r <= step_r + 5'h01;
              // 19 half periods end the conversion
              if (step_r == STEP_LAST) begin
                result_r <= dac_nxt;
                done_r <= 1'b1;
                hold_r <= 1'b0;
                state_r <= SAR_IDLE;
              end
            end
          end
        end
        default: state_r <= SAR_IDLE;
      endcase
    end
  end

  assign cif.busy = (state_r == SAR_RUN);
  assign cif.done = done_r;
  assign cif.result = result_r;
  assign cif.dac = dac_r;
  assign cif.hold = hold_r;

  // checks: cycles spent per conversion
  logic [11:0] run_cyc_r;
  logic slept_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cyc_r <= 12'h000;
      slept_r <= 1'b0;
    end else if (state_r == SAR_IDLE && cif.start) begin
      run_cyc_r <= 12'h000;
      slept_r <= 1'b0;
    end else if (state_r == SAR_RUN) begin
      run_cyc_r <= run_cyc_r + 12'h001;
      slept_r <= slept_r | cif.sleep;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_conv_len;
    done_r && !slept_r |-> run_cyc_r == 12'(HALF_TICKS) * 12'(half_div(sel_r));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_sleep_freeze;
    state_r == SAR_RUN && cif.sleep && sel_r != CS_RC && !cif.abort
      |=> $stable(dac_r) && $stable(step_r);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("osc clock ran in sleep");

  property p_first_trial;
    tick && step_r == STEP_HOLD |=> dac_r == DAC_FIRST;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial code wrong");
endmodule // adcsq_sar
`default_nettype wire

/* rtl/adcsq_top.sv */
// The APB slave port is this design's own decision.
`default_nettype none
module adcsq_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcsq_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device side, same clock
  input wire logic device_sleep,
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic special_trigger,
  output logic conversion_done_flag,
  // analog side
  input wire logic comparator_in,
  output logic converter_power,
  output logic ref_external,
  output logic [3:0] pin_analog,
  output logic [1:0] channel_route,
  output logic channel_enable,
  output logic sample_hold,
  output logic [7:0] dac_code
);
  import adcsq_pkg::*;

  adcsq_conv_if cif ();

  // converter_control_a fields
  adcsq_clksel_type conv_clock_select_r;
  logic [2:0] channel_select_r;
  logic go_r;                      // conversion status
  logic converter_on_r;
  // other registers
  logic [2:0] pin_config_field_r;
  logic [7:0] result_byte_r;
  logic done_flag_r;
  // apb answer
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  // pin side outputs
  logic ref_ext_r;
  logic [3:0] pin_analog_r;
  logic [1:0] ch_route_r;
  logic ch_en_r;
  // comparator latch
  logic comp_latch_r;

  logic [9:0] reg_idx;
  logic mapped;
  logic wr_commit;
  logic wr_ctrl;
  logic wr_status;
  logic wr_pincfg;
  logic sw_start;
  logic hw_start;
  logic stop;
  logic start_req;
  logic [31:0] rd_mux;

  // register index from a byte address; unaligned low bits ignored
  function automatic logic [9:0] idx_of(input logic [APB_AW-1:0] a);
    idx_of = a[APB_AW-1:2];
  endfunction

  // known register check, used for decode and error answer
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == IDX_STATUS) || (i == IDX_RESULT) || (i == IDX_CTRL_A) ||
                (i == IDX_PINCFG);
  endfunction

  // analog mask and reference from the pin config field
  function automatic logic [4:0] pin_decode(input logic [2:0] pc);
    logic [4:0] r;
    r = 5'h00;
    if (pc[PC_MSB]) begin
      case (pc[1:0])
        2'b00: r = {1'b0, 4'b1011};     // pin 2 digital, supply reference
        2'b01: r = {1'b1, 4'b1011};     // pin 2 digital, pin 3 reference
        default: r = {1'b0, 4'b0000};   // all digital, supply reference
      endcase
    end else begin
      r = {pc[0], 4'b1111};             // all analog, pin 3 ref when bit 0
    end
    pin_decode = r;
  endfunction

  assign reg_idx = idx_of(paddr);
  assign mapped = is_mapped(reg_idx);
  // a write lands only at the edge where pready is seen high
  assign wr_commit = psel && penable && pready_r && pwrite && mapped;
  assign wr_ctrl = wr_commit && (reg_idx == IDX_CTRL_A);
  assign wr_status = wr_commit && (reg_idx == IDX_STATUS);
  assign wr_pincfg = wr_commit && (reg_idx == IDX_PINCFG);

  // go only honoured if already on; same-write enable is ignored
  assign sw_start = wr_ctrl && pwdata[GO_BIT] && converter_on_r;
  // special event trigger only while on, otherwise dropped
  assign hw_start = special_trigger && (compare_unit_mode_field == TRIG_MODE) &&
                    converter_on_r;
  // switching off aborts a running conversion
  assign stop = wr_ctrl && !pwdata[ON_BIT];
  // a new start in the finishing cycle wins over the hardware clear
  assign start_req = (sw_start || hw_start) && (!go_r || cif.done) && !stop;

  // read mux; bit 1 of control and unused bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      IDX_CTRL_A: begin
        rd_mux[CS_MSB:CS_LSB] = conv_clock_select_r;
        rd_mux[CH_MSB:CH_LSB] = channel_select_r;
        rd_mux[GO_BIT] = go_r;
        rd_mux[ON_BIT] = converter_on_r;
      end
      IDX_PINCFG: rd_mux[PC_MSB:0] = pin_config_field_r;
      IDX_RESULT: rd_mux[7:0] = result_byte_r;
      IDX_STATUS: rd_mux[DONE_BIT] = done_flag_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait cycle, then pready with data for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= !mapped;            // unmapped index answers with error
    end else begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // control fields; reset leaves off, channel 0, osc/2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clock_select_r <= CS_OSC2;
      channel_select_r <= CHSEL_RST;
      converter_on_r <= 1'b0;
    end else if (wr_ctrl) begin
      conv_clock_select_r <= adcsq_clksel_type'(pwdata[CS_MSB:CS_LSB]);
      channel_select_r <= pwdata[CH_MSB:CH_LSB];
      converter_on_r <= pwdata[ON_BIT];
    end
  end

  // conversion status: set by start, cleared by completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b0;
    end else if (stop) begin
      go_r <= 1'b0;
    end else if (start_req) begin
      go_r <= 1'b1;
    end else if (cif.done) begin
      go_r <= 1'b0;                    // software polls for this
    end
  end

  // pin config register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_config_field_r <= PINCFG_RST;
    end else if (wr_pincfg) begin
      pin_config_field_r <= pwdata[PC_MSB:0];
    end
  end

  // result byte loads at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_byte_r <= RESULT_RST;
    end else if (cif.done) begin
      result_byte_r <= cif.result;
    end
  end

  // done flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_r <= 1'b0;
    end else if (cif.done) begin
      done_flag_r <= 1'b1;
    end else if (wr_status && pwdata[DONE_BIT]) begin
      done_flag_r <= 1'b0;
    end
  end

  // pin side outputs, registered; reserved channel codes disable the mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ext_r <= 1'b0;
      pin_analog_r <= 4'hf;
      ch_route_r <= 2'h0;
      ch_en_r <= 1'b0;
    end else begin
      {ref_ext_r, pin_analog_r} <= pin_decode(pin_config_field_r);
      ch_route_r <= channel_select_r[1:0];
      ch_en_r <= converter_on_r && !channel_select_r[2];
    end
  end

  // comparator answers our own registered trial code, so it is strobed on pclk;
  // a two-flop stage would lag past a whole osc/2 bit period and skew decisions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_latch_r <= 1'b0;
    end else begin
      comp_latch_r <= comparator_in;
    end
  end

  // sequencer hookup
  assign cif.start = start_req;
  assign cif.abort = stop;
  assign cif.clk_sel = conv_clock_select_r;
  assign cif.sleep = device_sleep;
  assign cif.comp = comp_latch_r;

  adcsq_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conversion_done_flag = done_flag_r;
  assign converter_power = converter_on_r;   // off draws no current
  assign ref_external = ref_ext_r;
  assign pin_analog = pin_analog_r;
  assign channel_route = ch_route_r;
  assign channel_enable = ch_en_r;
  assign sample_hold = cif.hold;
  assign dac_code = cif.dac;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_go_needs_on;
    $rose(go_r) |-> $past(converter_on_r);
  endproperty
  a_go_needs_on: assert property (p_go_needs_on) else $error("go set while off");

  property p_unimpl_zero;
    pready_r && $past(reg_idx) == IDX_CTRL_A && !$past(pwrite) |-> prdata_r[1] == 1'b0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("bit 1 read nonzero");

  property p_done_clears_go;
    cif.done && !start_req |=> !go_r;
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("go not cleared");

  property p_done_loads;
    cif.done |=> result_byte_r == $past(cif.result) && done_flag_r;
  endproperty
  a_done_loads: assert property (p_done_loads) else $error("result or flag not loaded");

  sequence s_trig_on;
    special_trigger && compare_unit_mode_field == TRIG_MODE && converter_on_r && !go_r && !stop;
  endsequence
  sequence s_conv_running;
    go_r && cif.busy;
  endsequence
  property p_trig_start;
    s_trig_on |=> s_conv_running;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_trig_off;
    special_trigger && !converter_on_r && !go_r |=> !go_r;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger started while off");

  property p_off_aborts;
    stop |=> !go_r ##1 !cif.busy;
  endproperty
  a_off_aborts: assert property (p_off_aborts) else $error("off did not abort");

  property p_busy_reads_go;
    cif.busy && !cif.done |-> go_r;
  endproperty
  a_busy_reads_go: assert property (p_busy_reads_go) else $error("go low mid conversion");

  property p_pin_all_digital;
    pin_config_field_r[2:1] == 2'b11 |=> pin_analog_r == 4'h0 && !ref_ext_r;
  endproperty
  a_pin_all_digital: assert property (p_pin_all_digital) else $error("11x decode wrong");

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_apb_wait;
    psel && penable && !pready_r;
  endsequence
  property p_apb_answer;
    s_apb_setup ##1 s_apb_wait |=> pready_r;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready late");

  property p_unmapped_err;
    pready_r |-> pslverr_r == !$past(mapped);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("error answer wrong");

  property p_ctrl_fields;
    wr_ctrl |=> conv_clock_select_r == $past(pwdata[CS_MSB:CS_LSB]) &&
      channel_select_r == $past(pwdata[CH_MSB:CH_LSB]);
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control not stored");

  property p_go_off_ignored;
    wr_ctrl && pwdata[GO_BIT] && !converter_on_r && !go_r |=> !go_r;
  endproperty
  a_go_off_ignored: assert property (p_go_off_ignored) else $error("go taken while off");

  property p_flag_clear;
    wr_status && pwdata[DONE_BIT] && !cif.done |=> !done_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_ref_select;
    !pin_config_field_r[PC_MSB] |=> pin_analog_r == 4'hf &&
      ref_ext_r == $past(pin_config_field_r[0]);
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("reference wrong");

  property p_chan_reserved;
    channel_select_r[2] |=> !ch_en_r;
  endproperty
  a_chan_reserved: assert property (p_chan_reserved) else $error("reserved code routed");

  property p_chan_route;
    converter_on_r && !channel_select_r[2] |=> ch_en_r &&
      ch_route_r == $past(channel_select_r[1:0]);
  endproperty
  a_chan_route: assert property (p_chan_route) else $error("channel route wrong");
endmodule // adcsq_top
`default_nettype wire

/* testbench/adcsq_analog_model.sv */
`default_nettype none
// analog pin and comparator model seen by the converter
module adcsq_analog_model (
  // clock
  input wire logic pclk,
  // converter side
  input wire logic [7:0] dac_code,
  input wire logic sample_hold,
  // level on the selected channel
  input wire logic [7:0] level,
  // comparator back to the converter
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wobble_r = 1'b0; // filler pattern while not holding
  // free-running toggle so a stray sample is never a stable guess
  always_ff @(posedge pclk) begin
    wobble_r <= ~wobble_r;
  end
  // held level against trial code; outside hold the result is junk
  always_comb begin
    if (sample_hold) begin
      comparator_in = (level >= dac_code);
    end else begin
      comparator_in = wobble_r;
    end
  end
endmodule // adcsq_analog_model
`default_nettype wire

/* testbench/testbench.sv */
`default_nettype none
// self-checking bench for the converter control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsq_pkg::*;
  // row of a register access case
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic err;
  } adcsq_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, conversion_done_flag, comparator_in;
  logic device_sleep = 1'b0, special_trigger = 1'b0;
  logic [3:0] compare_unit_mode_field = 4'h0, pin_analog;
  logic converter_power, ref_external, channel_enable, sample_hold;
  logic [1:0] channel_route;
  logic [7:0] dac_code, level = 8'h00;
  logic [31:0] rd;
  logic er;
  int failures = 0, samples_checked = 0, n;
  adcsq_row_type rows [7];
  logic [4:0] pc_exp [8]; // {ref, pins} per pin config code
  // 100 MHz clock
  always #5 pclk = ~pclk;
  adcsq_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_sleep(device_sleep),
    .compare_unit_mode_field(compare_unit_mode_field), .special_trigger(special_trigger),
    .conversion_done_flag(conversion_done_flag), .comparator_in(comparator_in),
    .converter_power(converter_power), .ref_external(ref_external),
    .pin_analog(pin_analog), .channel_route(channel_route),
    .channel_enable(channel_enable), .sample_hold(sample_hold), .dac_code(dac_code));
  adcsq_analog_model analog (.pclk(pclk), .dac_code(dac_code),
    .sample_hold(sample_hold), .level(level), .comparator_in(comparator_in));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20) chk(0, 1, "pready never came");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count edges until the done flag shows, bounded
  task automatic wait_flag(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (conversion_done_flag !== 1'b1 && n < lim);
  endtask
  // full conversion on channel 1; exp 0 skips the timing check
  task automatic conv(input logic [1:0] sel, input logic [7:0] lvl, input int exp);
    level <= lvl;
    apb(1, IDX_CTRL_A, {sel, 6'b001001});
    apb(1, IDX_CTRL_A, {sel, 6'b001101});
    wait_flag(5000);
    // flag lags the last decision by one pclk
    if (exp != 0) chk(n, exp + 1, "conversion length");
    chk(channel_route, 2'd1, "channel route");
    chk(channel_enable, 1'b1, "channel enable");
    apb(0, IDX_CTRL_A, 0);
    chk(rd, {sel, 6'b001001}, "go cleared");
    apb(0, IDX_RESULT, 0);
    chk(rd, lvl, "result");
    apb(1, IDX_STATUS, 8'h01);
    apb(0, IDX_STATUS, 0);
    chk(rd, 0, "flag clear");
  endtask
  // verdict
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    $display("[ERR] %0t watchdog", $time);
    end_sim;
  end
  // main sequence
  initial begin
    rows = '{'{IDX_CTRL_A, 8'hff, 8'hf9, 0}, '{IDX_CTRL_A, 8'h00, 8'h00, 0},
      '{IDX_PINCFG, 8'hff, 8'h07, 0}, '{IDX_PINCFG, 8'h00, 8'h00, 0},
      '{IDX_RESULT, 8'haa, 8'h00, 0}, '{10'h3ff, 8'h55, 8'h00, 1},
      '{IDX_CTRL_A, 8'he1, 8'he1, 0}};
    pc_exp = '{5'h0f, 5'h17, 5'h0f, 5'h17, 5'h0b, 5'h13, 5'h00, 5'h00};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    chk(pin_analog, 4'hf, "pins after reset");
    chk(converter_power, 0, "power after reset");
    apb(0, IDX_CTRL_A, 0);
    chk(rd, 0, "ctrl reset");
    apb(0, IDX_STATUS, 0);
    chk(rd, 0, "flag reset");
    $display("test reset done");
    // register rows: write then read back
    foreach (rows[i]) begin
      apb(1, rows[i].idx, rows[i].wd);
      chk(er, rows[i].err, "write err");
      apb(0, rows[i].idx, 0);
      chk({er, rd[30:0]}, {rows[i].err, 23'h0, rows[i].rd}, "row read");
    end
    #1;
    chk(channel_enable, 0, "reserved channel");
    chk(converter_power, 1, "power on");
    chk(sample_hold, 0, "no conversion when off");
    $display("test registers done");
    // pin configuration codes
    for (int c = 0; c < 8; c++) begin
      apb(1, IDX_PINCFG, 8'(c));
      @(posedge pclk);
      #1;
      chk(ref_external, pc_exp[c][4], "reference");
      chk(pin_analog[2:0], pc_exp[c][2:0], "pins");
      if (!pc_exp[c][4]) chk(pin_analog[3], pc_exp[c][3], "pin 3");
    end
    apb(1, IDX_PINCFG, 0);
    $display("test pin config done");
    // each oscillator clock choice, then rc while asleep
    conv(2'b00, 8'h5a, HALF_TICKS * HALF_DIV2);
    conv(2'b01, 8'ha7, HALF_TICKS * HALF_DIV8);
    conv(2'b10, 8'hff, HALF_TICKS * HALF_DIV32);
    device_sleep <= 1'b1;
    conv(2'b11, 8'h00, HALF_TICKS * RC_HALF_CYC);
    $display("test clocks done");
    // oscillator clock pauses in sleep
    fork
      conv(2'b01, 8'h3c, 0);
      begin
        repeat (200) @(posedge pclk);
        #1;
        chk(conversion_done_flag, 0, "osc ran in sleep");
        @(posedge pclk);
        device_sleep <= 1'b0;
      end
    join
    $display("test sleep done");
    // abort by switching off mid conversion
    apb(1, IDX_CTRL_A, 8'h89);
    apb(1, IDX_CTRL_A, 8'h8d);
    repeat (50) @(posedge pclk);
    chk(sample_hold, 1, "holding mid conversion");
    apb(1, IDX_CTRL_A, 8'h00);
    apb(0, IDX_CTRL_A, 0);
    chk(rd, 0, "abort go");
    wait_flag(400);
    chk(conversion_done_flag, 0, "aborted flag");
    $display("test abort done");
    // compare trigger: off, wrong mode, then valid
    for (int t = 0; t < 3; t++) begin
      apb(1, IDX_CTRL_A, (t == 0) ? 8'h08 : 8'h09);
      @(posedge pclk);
      compare_unit_mode_field <= (t == 1) ? 4'h0 : TRIG_MODE;
      special_trigger <= 1'b1;
      @(posedge pclk);
      special_trigger <= 1'b0;
      apb(0, IDX_CTRL_A, 0);
      chk(rd[GO_BIT], (t == 2), "trigger start");
    end
    wait_flag(100);
    chk(conversion_done_flag, 1, "trigger done");
    $display("test trigger done");
    // reset in mid conversion
    apb(1, IDX_STATUS, 8'h01);
    apb(1, IDX_CTRL_A, 8'h8d);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_flag(400);
    chk(conversion_done_flag, 0, "aborted by reset");
    apb(0, IDX_CTRL_A, 0);
    chk({rd[30:0], converter_power}, 0, "reset off");
    $display("test mid reset done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
